/* File: sim/aitp_comm_model.sv */
// behavioural communication unit collecting telegram words
`timescale 1ns/1ps
`default_nettype none
module aitp_comm_model (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic stall_in,
  input wire logic valid_in,
  input wire logic [7:0] data_in,
  input wire logic last_in,
  output logic ready_out
);
  logic [7:0] low;
  logic [15:0] words [4];
  int idx;
  int tele_count;
  // a stall just withholds ready, as a busy unit would
  assign ready_out = !stall_in;
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      idx <= 0;
      tele_count <= 0;
    end else if (valid_in && ready_out) begin
      if (idx[0]) begin
        words[idx / 2] <= {data_in, low};
      end else begin
        low <= data_in;
      end
      idx <= last_in ? 0 : idx + 1;
      if (last_in) begin
        tele_count <= tele_count + 1;
      end
    end
  end
endmodule : aitp_comm_model
`default_nettype wire

/* File: sim/aitp_props.sv */
// concurrent checks on the telegram packer ports
`timescale 1ns/1ps
`default_nettype none
module aitp_props
  import aitp_pkg::*;
#(
  parameter int CONV_SLOT_CYCLES = 40
) (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic ADC_START_OUT,
  input wire logic [1:0] ADC_CHANNEL_OUT,
  input wire logic CFG_VALID_IN,
  input wire logic [7:0] CFG_CODE_IN,
  input wire logic CFG_OK_OUT,
  input wire logic TX_VALID_OUT,
  input wire logic TX_READY_IN,
  input wire logic [7:0] TX_DATA_OUT,
  input wire logic TX_LAST_OUT,
  input wire logic [3:0] WITH_STATUS_IN,
  input wire logic [3:0][15:0] RANGE_START_IN,
  input wire logic [3:0][15:0] RANGE_END_IN
);
  logic [2:0] byte_cnt;
  logic cfg_seen;
  logic take;
  logic [1:0] ch;
  assign take = TX_VALID_OUT && TX_READY_IN;
  assign ch = byte_cnt[2:1];
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      byte_cnt <= 3'h0;
      cfg_seen <= 1'b0;
    end else begin
      if (take) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
      if (CFG_OK_OUT) begin
        cfg_seen <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RESET_IN);
  sequence s_start;
    ADC_START_OUT;
  endsequence
  sequence s_gap;
    !ADC_START_OUT [*8];
  endsequence
  a_start_pulse: assert property (s_start |=> s_gap)
    else $error("conversion start repeated too soon");
  a_start_period: assert property (s_start |-> ##CONV_SLOT_CYCLES ADC_START_OUT)
    else $error("conversion start spacing wrong");
  a_chan_next: assert property (s_start |-> ADC_CHANNEL_OUT == $past(ADC_CHANNEL_OUT) + 2'h1)
    else $error("conversion channel out of order");
  a_tx_hold: assert property (TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT))
    else $error("stalled byte not held");
  a_cfg_answer: assert property (CFG_VALID_IN |=> CFG_OK_OUT == ($past(CFG_CODE_IN) == CFG_CODE))
    else $error("configuration answer wrong");
  a_no_cfg_tx: assert property (!cfg_seen |-> !TX_VALID_OUT)
    else $error("telegram sent without configuration");
  a_eight_bytes: assert property (take |-> TX_LAST_OUT == (byte_cnt == 3'h7))
    else $error("telegram length wrong");
  a_status_gap: assert property (take && !byte_cnt[0] && WITH_STATUS_IN[ch] && RANGE_START_IN[ch] == DEF_START
    && RANGE_END_IN[ch] == DEF_END |-> TX_DATA_OUT[3:2] == 2'b00)
    else $error("unused status bits set");
endmodule : aitp_props
bind aitp_top aitp_props #(.CONV_SLOT_CYCLES(CONV_SLOT_CYCLES)) props_u (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
  .ADC_START_OUT(ADC_START_OUT), .ADC_CHANNEL_OUT(ADC_CHANNEL_OUT), .CFG_VALID_IN(CFG_VALID_IN),
  .CFG_CODE_IN(CFG_CODE_IN), .CFG_OK_OUT(CFG_OK_OUT), .TX_VALID_OUT(TX_VALID_OUT), .TX_READY_IN(TX_READY_IN),
  .TX_DATA_OUT(TX_DATA_OUT), .TX_LAST_OUT(TX_LAST_OUT), .WITH_STATUS_IN(WITH_STATUS_IN),
  .RANGE_START_IN(RANGE_START_IN), .RANGE_END_IN(RANGE_END_IN));
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the telegram packer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import aitp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic adc_valid = 1'b0;
  logic [11:0] adc_code = 12'h000;
  logic hart = 1'b0;
  logic cfg_valid = 1'b0;
  logic [7:0] cfg_code = 8'h00;
  logic stall = 1'b0;
  logic [3:0][7:0] filt = '0, subst_pct = '0, sim_pct = '0;
  logic [3:0][15:0] min_v = '0, max_v = {4{16'hFFFF}}, r_start = {4{DEF_START}}, r_end = {4{DEF_END}};
  logic [3:0] with_st = 4'hF, line_en = 4'h4, s_st = 4'hF, s_line = 4'hF, s_inv = 4'hF, sim_m = '0, sim_inv = '0;
  logic [3:0][11:0] brk = {12'h000, 12'h258, 12'h000, 12'h000}, shrt = {4{12'hFFF}};
  logic [3:0][1:0] err = '0;
  logic [11:0] codes [4] = '{12'h271, 12'hC35, 12'h232, 12'h3E8};
  logic adc_start, cfg_ok, tx_valid, tx_ready, tx_last;
  logic [1:0] adc_ch;
  logic [3:0] invalid;
  logic [7:0] tx_data;
  int adc_wait = 0;
  int fails = 0;
  int check_count = 0;

  aitp_top #(.CONV_SLOT_CYCLES(40), .SEND_PERIOD_CYCLES(30)) dut_u (.CLK_IN(clk), .RESET_IN(rst),
    .ADC_START_OUT(adc_start), .ADC_CHANNEL_OUT(adc_ch), .ADC_VALID_IN(adc_valid), .ADC_CODE_IN(adc_code),
    .FILTER_PCT_IN(filt), .MIN_VALUE_IN(min_v), .MAX_VALUE_IN(max_v), .RANGE_START_IN(r_start),
    .RANGE_END_IN(r_end), .WITH_STATUS_IN(with_st), .LINE_CHECK_EN_IN(line_en), .BREAK_CODE_IN(brk),
    .SHORT_CODE_IN(shrt), .ERR_MODE_IN(err), .SUBST_PCT_IN(subst_pct), .SUBST_STATUS_IN(s_st),
    .SUBST_LINE_IN(s_line), .SUBST_INVALID_IN(s_inv), .SIM_MODE_IN(sim_m), .SIM_PCT_IN(sim_pct),
    .SIM_INVALID_IN(sim_inv), .HART_ACTIVE_IN(hart), .CFG_VALID_IN(cfg_valid), .CFG_CODE_IN(cfg_code),
    .CFG_OK_OUT(cfg_ok), .INVALID_OUT(invalid), .TX_VALID_OUT(tx_valid), .TX_READY_IN(tx_ready),
    .TX_DATA_OUT(tx_data), .TX_LAST_OUT(tx_last));
  aitp_comm_model comm_u (.clk_in(clk), .reset_in(rst), .stall_in(stall), .valid_in(tx_valid),
    .data_in(tx_data), .last_in(tx_last), .ready_out(tx_ready));

  initial begin
    forever #50 clk = ~clk;
  end
  // converter answers three cycles after each start
  always @(posedge clk) begin
    adc_valid <= 1'b0;
    if (adc_start) begin
      adc_wait <= 3;
    end else if (adc_wait > 0) begin
      adc_wait <= adc_wait - 1;
      if (adc_wait == 1) begin
        adc_valid <= 1'b1;
        adc_code <= codes[adc_ch];
      end
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  task automatic next_tele;
    int start;
    start = comm_u.tele_count;
    for (int i = 0; i < 400 && comm_u.tele_count == start; i++) @(posedge clk);
    if (comm_u.tele_count == start) begin
      fails++;
      test_done();
    end
  endtask : next_tele
  // two telegrams after a full round so no stale snapshot is seen
  task automatic settle;
    repeat (400) @(posedge clk);
    next_tele();
    next_tele();
  endtask : settle
  task automatic check_words(input logic [15:0] e0, e1, e2, e3, input logic [15:0] m);
    check("word1", comm_u.words[0] & m, e0);
    check("word2", comm_u.words[1] & m, e1);
    check("word3", comm_u.words[2] & m, e2);
    check("word4", comm_u.words[3] & m, e3);
  endtask : check_words

  task automatic t_config;
    check("channel", {14'h0000, adc_ch}, 16'h0003);
    repeat (100) @(posedge clk);
    check("telegrams", 16'(comm_u.tele_count), 16'h0000);
    foreach (codes[i]) begin
      @(posedge clk);
      cfg_valid <= 1'b1;
      cfg_code <= (i == 3) ? CFG_CODE : 8'h50 + 8'(i);
      @(posedge clk);
      cfg_valid <= 1'b0;
      @(posedge clk);
      #1;
      check("cfg_ok", {15'h0000, cfg_ok}, (i == 3) ? 16'h0001 : 16'h0000);
    end
  endtask : t_config
  task automatic t_field;
    settle();
    check_words(16'h2710, 16'hC350, 16'h2323, 16'h3E80, 16'hFFFF);
  endtask : t_field
  task automatic t_stall;
    @(posedge clk);
    stall <= 1'b1;
    repeat (60) @(posedge clk);
    check("held", {15'h0000, tx_valid}, 16'h0001);
    stall <= 1'b0;
    next_tele();
    check_words(16'h2710, 16'hC350, 16'h2323, 16'h3E80, 16'hFFFF);
  endtask : t_stall
  task automatic t_scale;
    @(posedge clk);
    max_v[1] <= 16'h9C40;
    r_start[3] <= 16'h0000;
    r_end[3] <= 16'h09C4;
    settle();
    check_words(16'h2710, 16'h9C40, 16'h2323, 16'h0177, 16'hFFFF);
    max_v[1] <= 16'hFFFF;
    r_start[3] <= DEF_START;
    r_end[3] <= DEF_END;
  endtask : t_scale
  task automatic t_modes;
    @(posedge clk);
    sim_m <= 4'h3;
    sim_pct[0] <= 8'h32;
    sim_inv[1] <= 1'b1;
    err[1] <= 2'h1;
    subst_pct[1] <= 8'hE7;
    err[2] <= 2'h2;
    codes[2] = 12'h659;
    settle();
    check_words(16'h7530, 16'h0000, 16'h6590, 16'h3E80, 16'hFFF0);
    check("invalid", {15'h0000, invalid[1]}, 16'h0001);
    brk[2] <= 12'h900;
    codes[2] = 12'h7D0;
    settle();
    check("last_valid", comm_u.words[2] & 16'hFFF0, 16'h6590);
  endtask : t_modes
  // ramp must lag the jump; with HART only one of three ticks snaps new values
  task automatic t_dynamics;
    logic [15:0] prev;
    int repeats;
    @(posedge clk);
    filt[3] <= 8'h0A;
    codes[3] = 12'h659;
    settle();
    check("filter_ramp", {15'h0000, comm_u.words[3] > 16'h3E8F && comm_u.words[3] < 16'h6590}, 16'h0001);
    hart <= 1'b1;
    next_tele();
    prev = comm_u.words[0];
    repeats = 0;
    for (int i = 0; i < 3; i++) begin
      sim_pct[0] <= 8'h10 + 8'(i);
      next_tele();
      if (comm_u.words[0] == prev) begin
        repeats++;
      end
      prev = comm_u.words[0];
    end
    check("hart_repeats", 16'(repeats), 16'h0002);
  endtask : t_dynamics

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_config();
    t_field();
    t_stall();
    t_scale();
    t_modes();
    t_dynamics();
    test_done();
  end
endmodule : tb_top
`default_nettype wire

/* File: verilog/aitp_byte_if.sv */
// byte stream carrier between the packer and its output buffer
`timescale 1ns/1ps
`default_nettype none
interface aitp_byte_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  logic last;
  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface : aitp_byte_if
`default_nettype wire

/* File: verilog/aitp_pkg.sv */
// constants and types shared by the analog input telegram packer
package aitp_pkg;
  localparam int NUM_CH = 32'h0000_0004;
  localparam int VAL_W = 32'h0000_0014;
  localparam int CLK_HZ = 32'h0098_9680;
  localparam int HZ_PER_MHZ = 32'h000F_4240;
  // conversion slot per channel; four slots make one round of 80 ms
  localparam int CONV_SLOT_US = 32'h0000_4E20;
  localparam int CONV_SLOT_CYC = CONV_SLOT_US * (CLK_HZ / HZ_PER_MHZ);
  localparam int ROUND_MS = 32'h0000_0050;
  // telegram period towards the communication unit, 6500 us
  localparam int SEND_PERIOD_US = 32'h0000_1964;
  localparam int SEND_PERIOD_CYC = SEND_PERIOD_US * (CLK_HZ / HZ_PER_MHZ);
  // converter codes: 25 mA full scale at 156.25 codes per mA
  localparam logic [11:0] CODE_4MA = 12'h271;
  localparam int CODE_SPAN = 32'h0000_09C4;
  localparam logic [11:0] CODE_LIVE_ZERO = 12'h240;
  localparam int PCT_DEN = 32'h0000_0064;
  localparam int FILT_DEN = 32'h0001_86A0;
  localparam logic [15:0] DEF_START = 16'h2710;
  localparam logic [15:0] DEF_END = 16'hC350;
  localparam logic [7:0] CFG_CODE = 8'h53;
  localparam logic [1:0] HART_SLOT = 2'h2;
  localparam int BIT_LIVE_ZERO = 32'h0000_0000;
  localparam int BIT_LINE_FAULT = 32'h0000_0001;
  localparam int VALUE_LSB = 32'h0000_0004;
  localparam logic [2:0] LAST_BYTE = 3'h7;
  localparam logic [1:0] RESET_CH = 2'h3;

  typedef enum logic [1:0] {
    ERR_CURRENT = 2'b00,
    ERR_SUBST = 2'b01,
    ERR_LAST = 2'b10
  } aitp_err_mode_type;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } aitp_tx_state_type;
endpackage : aitp_pkg

/* File: verilog/aitp_scale.sv */
// linear scaling of a fraction onto a start..end raw range
`timescale 1ns/1ps
`default_nettype none
module aitp_scale
  import aitp_pkg::*;
#(
  parameter int DEN = 100
) (
  input wire logic signed [VAL_W-1:0] num_in,
  input wire logic [15:0] start_in,
  input wire logic [15:0] end_in,
  output logic signed [VAL_W-1:0] value_out
);
  logic signed [VAL_W-1:0] span;
  logic signed [2*VAL_W-1:0] prod;
  logic signed [2*VAL_W-1:0] quot;

  always_comb begin
    span = $signed({4'h0, end_in}) - $signed({4'h0, start_in});
    prod = num_in * span;
    quot = prod / (2*VAL_W)'(DEN);
    // result is left unclamped; out-of-range values survive to the final limit
    value_out = $signed({4'h0, start_in}) + VAL_W'(quot);
  end
endmodule : aitp_scale
`default_nettype wire

/* File: verilog/aitp_skid.sv */
// two-entry byte buffer so that a stalled receiver loses nothing
`timescale 1ns/1ps
`default_nettype none
module aitp_skid
  import aitp_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  aitp_byte_if.snk up,
  aitp_byte_if.src down
);
  typedef struct packed {
    logic [1:0][8:0] ent;
    logic [1:0] count;
    logic rd;
    logic wr;
  } aitp_skid_state_type;

  aitp_skid_state_type s;
  aitp_skid_state_type next_s;
  logic push;
  logic pop;

  assign up.ready = (s.count != 2'h2);
  assign down.valid = (s.count != 2'h0);
  assign down.data = s.ent[s.rd][7:0];
  assign down.last = s.ent[s.rd][8];

  always_comb begin
    next_s = s;
    push = up.valid && up.ready;
    pop = down.valid && down.ready;
    if (push) begin
      next_s.ent[s.wr] = {up.last, up.data};
      next_s.wr = ~s.wr;
    end
    if (pop) begin
      next_s.rd = ~s.rd;
    end
    next_s.count = s.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : aitp_skid
`default_nettype wire

/* File: verilog/aitp_top.sv */
// four-channel current-loop readout that packs channel words into the cyclic telegram
//
// Contract
// - nonzero filter setting ramps each channel at that percent of range per second.
// - every transmitted value is clamped between its configured minimum and maximum.
// - on error with substitute mode, send the substitute percentage value.
// - substitute word may carry line-fault status and invalid flag, each selectable.
// - in simulation mode, send the simulation percentage value instead of the field.
// - simulation value flagged invalid counts as a fault and triggers the error mode.
// - each channel current 0 to 25 mA is converted with 12 bits.
// - 4 mA is 0 %, 20 mA is 100 %, 2500 steps; over/underrange kept.
// - one conversion round over all four channels takes 80 ms.
// - channel words go out every 6.5 ms, repeating values if nothing new.
// - with HART active, new values are taken only every third data cycle.
// - each channel value is an unsigned 16-bit word, 0 to 65535.
// - the four lowest bits of each word carry status.
// - status bits are dropped when scaling is not 10000 to 50000.
// - channel words are sent in ascending order, channel one first.
// - cyclic exchange runs only after the master presents configuration code 53.
// - bit 0 of the low byte flags loop current at or below 3.6 mA; the code's limit is code 576, about 3.69 mA.
// - bit 1 of the low byte is the line-fault flag, one meaning fault.
// - bits 2 and 3 are zero, value in bits 4 to 15, low byte first.
// - eight input bytes per telegram, no output bytes.
// - default scaling maps 0 % to 10000 and 100 % to 50000.
// - last-valid mode holds the final good value for as long as the fault lasts.
`timescale 1ns/1ps
`default_nettype none
module aitp_top
  import aitp_pkg::*;
#(
  parameter int CONV_SLOT_CYCLES = CONV_SLOT_CYC,
  parameter int SEND_PERIOD_CYCLES = SEND_PERIOD_CYC
) (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  output logic ADC_START_OUT,
  output logic [1:0] ADC_CHANNEL_OUT,
  input wire logic ADC_VALID_IN,
  input wire logic [11:0] ADC_CODE_IN,
  input wire logic [3:0][7:0] FILTER_PCT_IN,
  input wire logic [3:0][15:0] MIN_VALUE_IN,
  input wire logic [3:0][15:0] MAX_VALUE_IN,
  input wire logic [3:0][15:0] RANGE_START_IN,
  input wire logic [3:0][15:0] RANGE_END_IN,
  input wire logic [3:0] WITH_STATUS_IN,
  input wire logic [3:0] LINE_CHECK_EN_IN,
  input wire logic [3:0][11:0] BREAK_CODE_IN,
  input wire logic [3:0][11:0] SHORT_CODE_IN,
  input wire logic [3:0][1:0] ERR_MODE_IN,
  input wire logic [3:0][7:0] SUBST_PCT_IN,
  input wire logic [3:0] SUBST_STATUS_IN,
  input wire logic [3:0] SUBST_LINE_IN,
  input wire logic [3:0] SUBST_INVALID_IN,
  input wire logic [3:0] SIM_MODE_IN,
  input wire logic [3:0][7:0] SIM_PCT_IN,
  input wire logic [3:0] SIM_INVALID_IN,
  input wire logic HART_ACTIVE_IN,
  input wire logic CFG_VALID_IN,
  input wire logic [7:0] CFG_CODE_IN,
  output logic CFG_OK_OUT,
  output logic [3:0] INVALID_OUT,
  output logic TX_VALID_OUT,
  input wire logic TX_READY_IN,
  output logic [7:0] TX_DATA_OUT,
  output logic TX_LAST_OUT
);
  typedef struct packed {
    logic [17:0] conv_cnt;
    logic [1:0] conv_ch;
    logic conv_start;
    logic [16:0] send_cnt;
    logic [1:0] hart_cnt;
    logic [3:0] seeded;
    logic [3:0][VAL_W-1:0] filt;
    logic [3:0] line_fault;
    logic [3:0] live_zero;
    logic [3:0][15:0] last_good;
    logic [3:0][15:0] snap;
    logic [3:0] snap_inv;
    logic cfg_ok;
    aitp_tx_state_type tx_state;
    logic [2:0] byte_idx;
  } aitp_state_type;

  aitp_state_type s;
  aitp_state_type next_s;

  aitp_byte_if pack_bus ();
  aitp_byte_if out_bus ();

  logic signed [VAL_W-1:0] field_num;
  logic signed [VAL_W-1:0] field_scaled;
  logic [3:0][15:0] word;
  logic [3:0] fault;
  logic [3:0] inv;
  logic [3:0][15:0] good_value;
  logic signed [VAL_W-1:0] diff;
  logic [VAL_W-1:0] diff_mag;
  logic [15:0] span_mag;
  logic [39:0] step;
  logic conv_tick;
  logic send_tick;
  logic take_new;

  function automatic logic [15:0] clamp_word(input logic signed [VAL_W-1:0] v,
                                             input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] r;
    r = 16'(v);
    if (v < $signed({4'h0, lo})) begin
      r = lo;
    end else if (v > $signed({4'h0, hi})) begin
      r = hi;
    end
    return r;
  endfunction : clamp_word

  // offset from the 4 mA point; below-zero and above-range codes are kept
  assign field_num = $signed({8'h00, ADC_CODE_IN}) - $signed({8'h00, CODE_4MA});

  aitp_scale #(
    .DEN(CODE_SPAN)
  ) u_field_scale (
    .num_in(field_num),
    .start_in(RANGE_START_IN[s.conv_ch]),
    .end_in(RANGE_END_IN[s.conv_ch]),
    .value_out(field_scaled)
  );

  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic signed [VAL_W-1:0] subst_scaled;
      logic signed [VAL_W-1:0] sim_scaled;
      logic signed [VAL_W-1:0] base;
      logic default_scale;
      logic [15:0] out_value;
      logic [1:0] status;

      aitp_scale #(
        .DEN(PCT_DEN)
      ) u_subst (
        .num_in({{(VAL_W-8){SUBST_PCT_IN[c][7]}}, SUBST_PCT_IN[c]}),
        .start_in(RANGE_START_IN[c]),
        .end_in(RANGE_END_IN[c]),
        .value_out(subst_scaled)
      );

      aitp_scale #(
        .DEN(PCT_DEN)
      ) u_sim (
        .num_in({{(VAL_W-8){SIM_PCT_IN[c][7]}}, SIM_PCT_IN[c]}),
        .start_in(RANGE_START_IN[c]),
        .end_in(RANGE_END_IN[c]),
        .value_out(sim_scaled)
      );

      always_comb begin
        base = SIM_MODE_IN[c] ? sim_scaled : $signed(s.filt[c]);
        // a simulated channel is faulted only by its own invalid flag
        fault[c] = SIM_MODE_IN[c] ? SIM_INVALID_IN[c] : s.line_fault[c];
        good_value[c] = clamp_word(base, MIN_VALUE_IN[c], MAX_VALUE_IN[c]);
        status = {s.line_fault[c], s.live_zero[c]};
        inv[c] = 1'b0;
        out_value = good_value[c];
        if (fault[c]) begin
          unique case (ERR_MODE_IN[c])
            ERR_SUBST: begin
              out_value = clamp_word(subst_scaled, MIN_VALUE_IN[c], MAX_VALUE_IN[c]);
              status = {SUBST_STATUS_IN[c] && SUBST_LINE_IN[c] && s.line_fault[c], s.live_zero[c]};
              inv[c] = SUBST_STATUS_IN[c] && SUBST_INVALID_IN[c];
            end
            ERR_LAST: begin
              out_value = s.last_good[c];
            end
            ERR_CURRENT: begin
              out_value = good_value[c];
            end
            default: begin
              out_value = good_value[c];
            end
          endcase
        end
        default_scale = (RANGE_START_IN[c] == DEF_START) && (RANGE_END_IN[c] == DEF_END);
        if (WITH_STATUS_IN[c] && default_scale) begin
          word[c] = {out_value[15:VALUE_LSB], 2'b00, status};
        end else begin
          word[c] = out_value;
        end
      end
    end
  endgenerate

  assign conv_tick = (s.conv_cnt == 18'(CONV_SLOT_CYCLES - 1));
  assign send_tick = (s.send_cnt == 17'(SEND_PERIOD_CYCLES - 1));
  assign take_new = !HART_ACTIVE_IN || (s.hart_cnt == HART_SLOT);

  always_comb begin
    next_s = s;
    next_s.conv_start = 1'b0;
    diff = '0;
    diff_mag = '0;
    span_mag = '0;
    step = '0;

    // one channel per slot, four slots per 80 ms round
    if (conv_tick) begin
      next_s.conv_cnt = '0;
      next_s.conv_ch = s.conv_ch + 2'h1;
      next_s.conv_start = 1'b1;
    end else begin
      next_s.conv_cnt = s.conv_cnt + 18'h0_0001;
    end

    if (ADC_VALID_IN) begin
      next_s.live_zero[s.conv_ch] = (ADC_CODE_IN <= CODE_LIVE_ZERO);
      next_s.line_fault[s.conv_ch] = LINE_CHECK_EN_IN[s.conv_ch]
        && ((ADC_CODE_IN < BREAK_CODE_IN[s.conv_ch]) || (ADC_CODE_IN > SHORT_CODE_IN[s.conv_ch]));
      span_mag = (RANGE_END_IN[s.conv_ch] >= RANGE_START_IN[s.conv_ch])
        ? RANGE_END_IN[s.conv_ch] - RANGE_START_IN[s.conv_ch]
        : RANGE_START_IN[s.conv_ch] - RANGE_END_IN[s.conv_ch];
      // updates of one channel are one round apart, so the step covers 80 ms
      step = 40'(FILTER_PCT_IN[s.conv_ch]) * 40'(span_mag) * 40'(ROUND_MS) / 40'(FILT_DEN);
      if (step == 40'h00_0000_0000) begin
        step = 40'h00_0000_0001;
      end
      diff = field_scaled - $signed(s.filt[s.conv_ch]);
      diff_mag = diff[VAL_W-1] ? VAL_W'(-diff) : VAL_W'(diff);
      next_s.seeded[s.conv_ch] = 1'b1;
      if (FILTER_PCT_IN[s.conv_ch] == 8'h00 || !s.seeded[s.conv_ch]
          || 40'(diff_mag) <= step) begin
        next_s.filt[s.conv_ch] = field_scaled;
      end else if (diff[VAL_W-1]) begin
        next_s.filt[s.conv_ch] = s.filt[s.conv_ch] - step[VAL_W-1:0];
      end else begin
        next_s.filt[s.conv_ch] = s.filt[s.conv_ch] + step[VAL_W-1:0];
      end
    end

    for (int c = 0; c < NUM_CH; c++) begin
      if (!fault[c]) begin
        next_s.last_good[c] = good_value[c];
      end
    end

    if (CFG_VALID_IN) begin
      next_s.cfg_ok = (CFG_CODE_IN == CFG_CODE);
    end

    if (send_tick) begin
      next_s.send_cnt = '0;
      next_s.hart_cnt = (!HART_ACTIVE_IN || s.hart_cnt == HART_SLOT) ? 2'h0 : s.hart_cnt + 2'h1;
      // a period that finds the telegram still stalled is skipped whole
      if (s.tx_state == TX_IDLE) begin
        if (take_new) begin
          next_s.snap = word;
          next_s.snap_inv = inv;
        end
        if (s.cfg_ok) begin
          next_s.tx_state = TX_SEND;
          next_s.byte_idx = 3'h0;
        end
      end
    end else begin
      next_s.send_cnt = s.send_cnt + 17'h0_0001;
    end

    unique case (s.tx_state)
      TX_IDLE: begin
      end
      TX_SEND: begin
        if (pack_bus.ready) begin
          next_s.byte_idx = s.byte_idx + 3'h1;
          if (s.byte_idx == LAST_BYTE) begin
            next_s.tx_state = TX_IDLE;
          end
        end
      end
    endcase
  end

  // channel one first, low byte before high byte
  assign pack_bus.valid = (s.tx_state == TX_SEND);
  assign pack_bus.data = s.byte_idx[0] ? s.snap[s.byte_idx[2:1]][15:8]
                                       : s.snap[s.byte_idx[2:1]][7:0];
  assign pack_bus.last = (s.byte_idx == LAST_BYTE);

  aitp_skid u_skid (
    .clk_in(CLK_IN),
    .reset_in(RESET_IN),
    .up(pack_bus),
    .down(out_bus)
  );

  assign out_bus.ready = TX_READY_IN;
  assign TX_VALID_OUT = out_bus.valid;
  assign TX_DATA_OUT = out_bus.data;
  assign TX_LAST_OUT = out_bus.last;
  assign ADC_START_OUT = s.conv_start;
  assign ADC_CHANNEL_OUT = s.conv_ch;
  assign CFG_OK_OUT = s.cfg_ok;
  assign INVALID_OUT = s.snap_inv;

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      s <= '0;
      s.conv_ch <= RESET_CH;
      s.tx_state <= TX_IDLE;
    end else begin
      s <= next_s;
    end
  end
endmodule : aitp_top
`default_nettype wire
